// file: include/eimc_pkg.sv
// package for the external interrupt mode and mask control block
package eimc_pkg;
    // ---------------------------------------------------------------
    // register byte addresses
    // ---------------------------------------------------------------
    localparam logic [4:0] EIMC_CTRL_OFS = 5'h00;
    localparam logic [4:0] EIMC_STS_OFS = 5'h04;
    localparam logic [4:0] EIMC_MSK_OFS = 5'h08;
    // ---------------------------------------------------------------
    // control field positions and reset values
    // ---------------------------------------------------------------
    localparam int EIMC_MAI_BIT = 15;
    localparam int EIMC_LVL_BIT = 14;
    localparam int EIMC_BLO_BIT = 13;
    localparam int EIMC_RSVD_BIT = 12;
    localparam int EIMC_SNS_HI = 11;
    localparam int EIMC_SNS_LO = 10;
    localparam logic EIMC_MAI_RST = 1'b0;
    localparam logic EIMC_LVL_RST = 1'b1;
    localparam logic EIMC_BLO_RST = 1'b0;
    localparam logic [1:0] EIMC_SNS_RST = 2'b00;
    localparam logic [5:0] EIMC_EV_RST = 6'h00;
    localparam logic [5:0] EIMC_PIN_RST = 6'h3f;
    // event and status bit positions: nmi, lower pins, line 5
    localparam int EIMC_EV_NMI = 0;
    localparam int EIMC_EV_LOW = 1;
    localparam int EIMC_EV_L5 = 5;
    localparam int EIMC_NEV = 6;
    // ---------------------------------------------------------------
    // line 5 sense modes and bus answers
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        EIMC_SNS_FALL = 2'b00,
        EIMC_SNS_RISE = 2'b01,
        EIMC_SNS_LOW = 2'b10,
        EIMC_SNS_LOW2 = 2'b11
    } eimc_sense_t;
    localparam logic [1:0] EIMC_RESP_OK = 2'b00;
    localparam logic [1:0] EIMC_RESP_ERR = 2'b10;
    // ---------------------------------------------------------------
    // carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic nmi;
        logic [3:0] lower;
        logic line5;
    } eimc_pins_t;
    typedef struct packed {
        logic mask_all_on_nmi_low;
        logic lvl;
        logic blo;
        eimc_sense_t sense5;
        logic [5:0] sts;
        logic [5:0] msk;
        logic [5:0] pend;
        logic [5:0] prev;
        logic [3:0] enc;
        logic aw_got;
        logic w_got;
        logic [4:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } eimc_state_t;
endpackage

// file: src/eimc_top.sv
// external request mode select, nmi-low masking and line 5 sense control
`timescale 1ns/1ps
module eimc_top
    import eimc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic nmi_pin_i,
    input wire logic [3:0] lower_request_pins_i,
    input wire logic line5_pin_i,
    input wire logic cpu_block_bit_i,
    input wire logic [5:0] req_ack_i,
    output logic nmi_req_o,
    output logic [3:0] lower_req_o,
    output logic [3:0] encoded_request_lines_o,
    output logic line5_req_o,
    output logic irq_o
);
    // ---------------------------------------------------------------
    // pin events
    // ---------------------------------------------------------------
    eimc_state_t q;
    eimc_state_t next_q;
    eimc_pins_t pins;
    logic [5:0] pv;
    logic [5:0] ev;
    logic block_all;
    logic [15:0] ctrl_rd;
    logic aw_hs;
    logic w_hs;
    logic do_wr;
    logic [5:0] w1c;

    assign pins = '{nmi: nmi_pin_i, lower: lower_request_pins_i, line5: line5_pin_i};
    assign pv = {pins.line5, pins.lower, pins.nmi};
    assign block_all = q.mask_all_on_nmi_low && !nmi_pin_i;

    genvar gi;
    generate
        for (gi = 0; gi < EIMC_NEV; gi++) begin : g_ev
            if (gi == EIMC_EV_L5) begin : g_l5
                always_comb begin
                    case (q.sense5)
                        EIMC_SNS_FALL: ev[gi] = q.prev[gi] && !pv[gi];
                        EIMC_SNS_RISE: ev[gi] = !q.prev[gi] && pv[gi];
                        default: ev[gi] = !pv[gi];
                    endcase
                end
            end else if (gi == EIMC_EV_NMI) begin : g_nmi
                assign ev[gi] = q.prev[gi] && !pv[gi];
            end else begin : g_low
                // encoded mode: the pins carry a level word, not edges
                assign ev[gi] = !q.lvl && q.prev[gi] && !pv[gi];
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // bus handshakes
    // ---------------------------------------------------------------
    assign s_axi_awready = !q.aw_got && !q.bvalid;
    assign s_axi_wready = !q.w_got && !q.bvalid;
    assign s_axi_arready = !q.rvalid;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign do_wr = q.aw_got && q.w_got && !q.bvalid;
    assign w1c = (do_wr && q.waddr == EIMC_STS_OFS && q.wstrb[0]) ? q.wdata[5:0] : 6'h00;

    always_comb begin
        ctrl_rd = 16'h0000;
        ctrl_rd[EIMC_MAI_BIT] = q.mask_all_on_nmi_low;
        ctrl_rd[EIMC_LVL_BIT] = q.lvl;
        ctrl_rd[EIMC_BLO_BIT] = q.blo;
        ctrl_rd[EIMC_RSVD_BIT] = 1'b0;
        ctrl_rd[EIMC_SNS_HI:EIMC_SNS_LO] = q.sense5;
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        next_q = q;
        next_q.prev = pv;
        // a new event beats a same-cycle acknowledge or clear
        next_q.pend = (q.pend & ~req_ack_i) | ev;
        if (q.lvl) begin
            next_q.pend[4:1] = 4'h0;
        end
        next_q.sts = (q.sts & ~w1c) | ev;
        next_q.enc = (q.lvl && !block_all) ? ~pins.lower : 4'h0;
        if (aw_hs) begin
            next_q.aw_got = 1'b1;
            next_q.waddr = s_axi_awaddr;
        end
        if (w_hs) begin
            next_q.w_got = 1'b1;
            next_q.wdata = s_axi_wdata;
            next_q.wstrb = s_axi_wstrb;
        end
        if (do_wr) begin
            next_q.aw_got = 1'b0;
            next_q.w_got = 1'b0;
            next_q.bvalid = 1'b1;
            next_q.bresp = EIMC_RESP_OK;
            case (q.waddr)
                EIMC_CTRL_OFS: begin
                    if (q.wstrb[1]) begin
                        next_q.mask_all_on_nmi_low = q.wdata[EIMC_MAI_BIT];
                        next_q.lvl = q.wdata[EIMC_LVL_BIT];
                        next_q.blo = q.wdata[EIMC_BLO_BIT];
                        next_q.sense5 = eimc_sense_t'(q.wdata[EIMC_SNS_HI:EIMC_SNS_LO]);
                    end
                end
                EIMC_STS_OFS: begin
                end
                EIMC_MSK_OFS: begin
                    if (q.wstrb[0]) begin
                        next_q.msk = q.wdata[5:0];
                    end
                end
                default: next_q.bresp = EIMC_RESP_ERR;
            endcase
        end
        if (q.bvalid && s_axi_bready) begin
            next_q.bvalid = 1'b0;
        end
        if (q.rvalid && s_axi_rready) begin
            next_q.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_q.rvalid = 1'b1;
            next_q.rresp = EIMC_RESP_OK;
            case (s_axi_araddr)
                EIMC_CTRL_OFS: next_q.rdata = {16'h0000, ctrl_rd};
                EIMC_STS_OFS: next_q.rdata = {26'h000_0000, q.sts};
                EIMC_MSK_OFS: next_q.rdata = {26'h000_0000, q.msk};
                default: begin
                    next_q.rdata = 32'h0000_0000;
                    next_q.rresp = EIMC_RESP_ERR;
                end
            endcase
        end
        if (srst_i) begin
            next_q = '0;
            next_q.mask_all_on_nmi_low = EIMC_MAI_RST;
            next_q.lvl = EIMC_LVL_RST;
            next_q.blo = EIMC_BLO_RST;
            next_q.sense5 = eimc_sense_t'(EIMC_SNS_RST);
            next_q.pend = EIMC_EV_RST;
            next_q.prev = EIMC_PIN_RST;
        end
    end

    always_ff @(posedge core_clk_i) begin
        q <= next_q;
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = q.rdata;
    // nmi honours the cpu block bit unless the override is set
    assign nmi_req_o = q.pend[EIMC_EV_NMI] && !block_all
        && (q.blo || !cpu_block_bit_i);
    assign lower_req_o = (q.lvl || block_all) ? 4'h0 : q.pend[4:1];
    assign encoded_request_lines_o = q.enc;
    assign line5_req_o = q.pend[EIMC_EV_L5] && !block_all;
    assign irq_o = |(q.sts & q.msk) && !block_all;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    mask_all_low_a: assert property (q.mask_all_on_nmi_low && !nmi_pin_i |->
        !nmi_req_o && lower_req_o == 4'h0 && !line5_req_o && !irq_o)
        else $error("request passed while nmi low and mask-all set");
    no_mask_a: assert property (!q.mask_all_on_nmi_low && q.pend[5] |-> line5_req_o)
        else $error("request blocked with mask-all clear");
    ctrl_reset_a: assert property ($past(srst_i) |->
        q.lvl && !q.mask_all_on_nmi_low && !q.blo && q.sense5 == EIMC_SNS_FALL)
        else $error("control reset value wrong");
    indep_edge_a: assert property (!q.lvl && !block_all && q.prev[1] && !pv[1]
        && !req_ack_i[1] && !q.mask_all_on_nmi_low |=> q.pend[1] && (q.lvl || lower_req_o[0]))
        else $error("independent pin edge not latched");
    encoded_word_a: assert property (q.lvl && !block_all |=>
        encoded_request_lines_o == ~$past(lower_request_pins_i) && lower_req_o == 4'h0)
        else $error("encoded word wrong");
    nmi_block_a: assert property (!q.blo && cpu_block_bit_i |-> !nmi_req_o)
        else $error("nmi passed with block bit set");
    nmi_override_a: assert property (q.blo && q.pend[0] && !block_all |-> nmi_req_o)
        else $error("nmi not accepted under override");
    rsvd_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[12] == 1'b0)
        else $error("reserved bit read as one");
    line5_fall_a: assert property (q.sense5 == EIMC_SNS_FALL && $fell(line5_pin_i)
        |-> ##1 q.pend[5])
        else $error("line 5 falling edge missed");
    line5_rise_a: assert property (q.sense5 == EIMC_SNS_RISE && q.prev[5]
        && !pv[5] && !req_ack_i[5] && !q.pend[5] |=> !q.pend[5])
        else $error("line 5 rising mode took a falling edge");
    latch_hold_a: assert property (q.pend[5] && !req_ack_i[5] |=> q.pend[5])
        else $error("latched request dropped without acknowledge");

    mask_cov: cover property (q.mask_all_on_nmi_low && !nmi_pin_i && q.pend != 6'h00);
    enc_cov: cover property (q.lvl && encoded_request_lines_o == 4'hf);
    nmi_cov: cover property (q.blo && cpu_block_bit_i && nmi_req_o);
    wr_cov: cover property (s_axi_bvalid && s_axi_bready);
endmodule // eimc_top

// file: verif/eimc_ext_src.sv
// far-side model: external request sources, cpu block bit and request acknowledge
`timescale 1ns/1ps
module eimc_ext_src
    import eimc_pkg::*;
(
    input wire logic core_clk_i,
    input wire eimc_pins_t want_i,
    input wire logic want_blk_i,
    input wire logic [5:0] want_ack_i,
    output eimc_pins_t pins_o,
    output logic cpu_block_bit_o,
    output logic [5:0] req_ack_o
);
    // pins idle high: the request pins are active low, so idle must not look like a request
    initial {pins_o, cpu_block_bit_o, req_ack_o} = {6'h3f, 1'b0, 6'h00};
    // sources move just after an edge, never on the design's sampling instant
    always @(posedge core_clk_i) begin
        {pins_o, cpu_block_bit_o, req_ack_o} <= {want_i, want_blk_i, want_ack_i};
    end
endmodule // eimc_ext_src

// file: verif/eimc_top_tb.sv
// self-checking bench for the external request mode and mask control block
`timescale 1ns/1ps
module eimc_top_tb
    import eimc_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, prb = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, blk;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    eimc_pins_t want = 6'h3f, pins;
    logic want_blk = 1'b0;
    logic [5:0] want_ack = 6'h00, ack;
    wire [10:0] outs;
    logic [2:0] go;
    logic [15:0] seed = 16'h3526;
    logic [3:0] p;
    logic [33:0] exp_q[$];
    int checks = 0;
    int bad_count = 0;
    always #5 core_clk_i = ~core_clk_i;
    eimc_top uut (
        .core_clk_i(core_clk_i), .srst_i(srst_i), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(1'b1), .nmi_pin_i(pins.nmi), .lower_request_pins_i(pins.lower),
        .line5_pin_i(pins.line5), .cpu_block_bit_i(blk), .req_ack_i(ack),
        .nmi_req_o(outs[9]), .lower_req_o(outs[8:5]), .encoded_request_lines_o(outs[4:1]),
        .line5_req_o(outs[0]), .irq_o(outs[10])
    );
    eimc_ext_src far (.core_clk_i(core_clk_i), .want_i(want), .want_blk_i(want_blk),
        .want_ack_i(want_ack), .pins_o(pins), .cpu_block_bit_o(blk), .req_ack_o(ack));
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [33:0] g);
        logic [33:0] e;
        e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t ns: got %h expected %h", $time, g, e);
        end
    endtask
    // readies are looked at on the falling edge, so the value seen is the one the next
    // rising edge samples; requests are released only after that edge
    task automatic bus(input logic is_rd, input logic [4:0] a, input logic [31:0] d,
                       input logic [33:0] e);
        int n;
        logic fin;
        exp_q.push_back(e);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_arvalid <= is_rd;
        s_axi_awvalid <= !is_rd;
        s_axi_wvalid <= !is_rd;
        fin = 1'b0;
        for (n = 0; n < 40 && !fin; n++) begin
            @(negedge core_clk_i);
            fin = is_rd ? s_axi_rvalid : s_axi_bvalid;
            go = {s_axi_arready, s_axi_awready, s_axi_wready};
            @(posedge core_clk_i);
            if (go[2]) s_axi_arvalid <= 1'b0;
            if (go[1]) s_axi_awvalid <= 1'b0;
            if (go[0]) s_axi_wvalid <= 1'b0;
        end
        if (!fin) begin
            bad_count++;
            close_out();
        end
    endtask
    task automatic setp(input eimc_pins_t v, input logic b);
        want <= v;
        want_blk <= b;
        repeat (3) @(posedge core_clk_i);
    endtask
    task automatic probe(input logic [10:0] v);
        exp_q.push_back({23'h00_0000, v});
        prb <= 1'b1;
        @(posedge core_clk_i);
        prb <= 1'b0;
    endtask
    task automatic clr();
        want_ack <= 6'h3f;
        @(posedge core_clk_i);
        want_ack <= 6'h00;
        repeat (2) @(posedge core_clk_i);
        bus(1'b0, EIMC_STS_OFS, 32'h0000_003f, 34'h0_0000_0000);
    endtask
    always @(negedge core_clk_i) begin
        if (s_axi_bvalid) cmp({s_axi_bresp, 32'h0000_0000});
        if (s_axi_rvalid) cmp({s_axi_rresp, s_axi_rdata});
        if (prb) cmp({23'h00_0000, outs});
    end
    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (2) @(posedge core_clk_i);
        srst_i <= 1'b0;
        @(posedge core_clk_i);
        bus(1'b1, EIMC_CTRL_OFS, 32'h0, {2'b00, 32'h0000_4000});
        bus(1'b1, EIMC_STS_OFS, 32'h0, 34'h0_0000_0000);
        bus(1'b1, EIMC_MSK_OFS, 32'h0, 34'h0_0000_0000);
        bus(1'b0, EIMC_CTRL_OFS, 32'hffff_efff, 34'h0_0000_0000);
        bus(1'b1, EIMC_CTRL_OFS, 32'h0, {2'b00, 32'h0000_ec00});
        bus(1'b0, 5'h0c, 32'h0, {EIMC_RESP_ERR, 32'h0000_0000});
        bus(1'b1, 5'h0c, 32'h0, {EIMC_RESP_ERR, 32'h0000_0000});
        $display("test registers done");
        bus(1'b0, EIMC_MSK_OFS, 32'h0000_003f, 34'h0_0000_0000);
        for (logic [2:0] m = 0; m < 4; m++) begin
            setp({5'h1f, m != 3'h1}, 1'b0);
            bus(1'b0, EIMC_CTRL_OFS, {20'h0_0000, m[1:0], 10'h000}, 34'h0_0000_0000);
            clr();
            probe(11'h000);
            setp({5'h1f, m == 3'h1}, 1'b0);
            probe({1'b1, 10'h001});
            setp({5'h1f, m != 3'h1}, 1'b0);
            probe({1'b1, 10'h001});
        end
        bus(1'b1, EIMC_STS_OFS, 32'h0, {2'b00, 32'h0000_0020});
        bus(1'b0, EIMC_MSK_OFS, 32'h0000_0000, 34'h0_0000_0000);
        probe({1'b0, 10'h001});
        clr();
        $display("test sense modes and interrupt done");
        bus(1'b0, EIMC_MSK_OFS, 32'h0000_003f, 34'h0_0000_0000);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            p = seed[3:0];
            bus(1'b0, EIMC_CTRL_OFS, 32'h0000_0000, 34'h0_0000_0000);
            setp({1'b1, p, 1'b1}, 1'b0);
            probe({p != 4'hf, 1'b0, ~p, 4'h0, 1'b0});
            setp(6'h3f, 1'b0);
            clr();
            bus(1'b0, EIMC_CTRL_OFS, 32'h0000_4000, 34'h0_0000_0000);
            setp({1'b1, p, 1'b1}, 1'b0);
            probe({2'b00, 4'h0, ~p, 1'b0});
            setp(6'h3f, 1'b0);
        end
        $display("test request pin modes done");
        setp({1'b0, 4'hf, 1'b1}, 1'b1);
        probe({2'b10, 9'h000});
        bus(1'b0, EIMC_CTRL_OFS, 32'h0000_6000, 34'h0_0000_0000);
        probe({2'b11, 9'h000});
        bus(1'b0, EIMC_CTRL_OFS, 32'h0000_c000, 34'h0_0000_0000);
        probe(11'h000);
        setp(6'h3f, 1'b0);
        probe({2'b11, 9'h000});
        $display("test nmi control done");
        repeat (2) @(posedge core_clk_i);
        close_out();
    end
endmodule // eimc_top_tb
